// File: src/fmd_pkg.sv
// Package of constants and types for the factory-mode accessory detector.
package fmd_pkg;

  // ----------------------------------------------------------------------
  // Clock and time units
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;

  // ----------------------------------------------------------------------
  // Timing code tables, values in milliseconds
  // ----------------------------------------------------------------------
  localparam int ADC_BASE_MS   = 50;
  localparam int ADC_STEP1_MS  = 50;
  localparam int ADC_KNEE_CODE = 3;
  localparam int ADC_STEP2_MS  = 100;
  localparam int ADC_MAX_CODE  = 11;
  localparam int KEY_BASE_MS   = 100;
  localparam int KEY_STEP_MS   = 100;
  localparam int KEY_MAX_CODE  = 9;
  localparam int LKEY_BASE_MS  = 300;
  localparam int LKEY_STEP_MS  = 100;
  localparam int LKEY_MAX_CODE = 12;
  localparam int SWW_BASE_MS   = 10;
  localparam int SWW_STEP_MS   = 20;
  localparam int SWW_MAX_CODE  = 10;
  localparam int TIME_W        = 11;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_TIMING = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_INT    = 4'h2;
  localparam logic [3:0] ADDR_MASK   = 4'h3;
  localparam logic [3:0] ADDR_TIMES  = 4'h4;
  localparam logic [15:0] TIMING_RST = 16'h0000;
  localparam int TF_ADC  = 0;
  localparam int TF_KEY  = 4;
  localparam int TF_LKEY = 8;
  localparam int TF_SWW  = 12;
  localparam int NUM_INT = 3;
  localparam int INT_ENTER  = 0;
  localparam int INT_CHANGE = 1;
  localparam int INT_EXIT   = 2;
  localparam logic [2:0] MASK_RST = 3'h0;

  // ----------------------------------------------------------------------
  // ID resistor classes and switch routes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMD_ID_NONE, FMD_ID_619K, FMD_ID_523K, FMD_ID_301K,
    FMD_ID_255K, FMD_ID_1000K, FMD_ID_1002K, FMD_ID_OTHER
  } fmd_id_t;

  typedef enum logic [1:0] {
    FMD_RT_OPEN, FMD_RT_UART, FMD_RT_USB, FMD_RT_AUDIO
  } fmd_route_t;

endpackage : fmd_pkg

// File: src/fmd_time_decode.sv
// Decoder of the four 4-bit timing codes into milliseconds.
module fmd_time_decode
  import fmd_pkg::*;
(
  input  wire logic [3:0]        i_adc_code,
  input  wire logic [3:0]        i_key_code,
  input  wire logic [3:0]        i_lkey_code,
  input  wire logic [3:0]        i_sww_code,
  output logic [fmd_pkg::TIME_W-1:0] o_adc_ms,
  output logic [fmd_pkg::TIME_W-1:0] o_key_ms,
  output logic [fmd_pkg::TIME_W-1:0] o_lkey_ms,
  output logic [fmd_pkg::TIME_W-1:0] o_sww_ms,
  output logic [3:0]             o_valid
);
  import fmd_pkg::*;

  // Undefined codes decode to zero with their valid bit low.
  always_comb begin
    o_adc_ms  = '0;
    o_key_ms  = '0;
    o_lkey_ms = '0;
    o_sww_ms  = '0;
    o_valid   = 4'h0;
    if (int'(i_adc_code) <= ADC_KNEE_CODE) begin
      o_adc_ms = TIME_W'(ADC_BASE_MS + ADC_STEP1_MS * int'(i_adc_code));
      o_valid[0] = 1'b1;
    end else if (int'(i_adc_code) <= ADC_MAX_CODE) begin
      o_adc_ms = TIME_W'(ADC_BASE_MS + ADC_STEP1_MS * ADC_KNEE_CODE
                 + ADC_STEP2_MS * (int'(i_adc_code) - ADC_KNEE_CODE));
      o_valid[0] = 1'b1;
    end
    if (int'(i_key_code) <= KEY_MAX_CODE) begin
      o_key_ms = TIME_W'(KEY_BASE_MS + KEY_STEP_MS * int'(i_key_code));
      o_valid[1] = 1'b1;
    end
    if (int'(i_lkey_code) <= LKEY_MAX_CODE) begin
      o_lkey_ms = TIME_W'(LKEY_BASE_MS + LKEY_STEP_MS * int'(i_lkey_code));
      o_valid[2] = 1'b1;
    end
    if (int'(i_sww_code) <= SWW_MAX_CODE) begin
      o_sww_ms = TIME_W'(SWW_BASE_MS + SWW_STEP_MS * int'(i_sww_code));
      o_valid[3] = 1'b1;
    end
  end

endmodule // fmd_time_decode

// File: src/fmd_factory_detect.sv
// Factory-mode accessory detector: ID class to switch routes and outputs.
// Summary of operation
// - Decode ADC and key press timing codes.
// - Four timing fields; long key, wait decode.
// - Jig with IO supply configures paths automatically.
// - Initial factory setup: no ack, no wait.
// - ID change in factory mode reconfigures directly.
// - Jig output held low in all modes; boot per mode.
// - Removal returns to standard attach flow.
// - Key sensing disabled in factory mode.
// - 619k/523k route UART, jig low, charger Hi-Z.
// - 301k/255k route USB host, close charger FET.
// - UART modes close FET if bus valid then.
// - Audio type 1 only after jig-low entry.
//
// Design decisions made here: the register offsets and the plain strobed port.
module fmd_factory_detect
  import fmd_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire fmd_pkg::fmd_id_t  i_id_class,
  input  wire logic              i_io_supply,
  input  wire logic              i_bus_supply_input,
  input  wire logic [3:0]        i_addr,
  input  wire logic [15:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [15:0]            o_rdata,
  output fmd_pkg::fmd_route_t    o_route,
  output logic                   o_factory,
  output logic                   o_jig_present,
  output logic                   o_boot_request,
  output logic                   o_charger_fet,
  output logic                   o_charger_detect_out_oe,
  output logic                   o_microphone_line_en,
  output logic                   o_key_sense_en,
  output logic                   o_irq
);
  import fmd_pkg::*;

  // ----------------------------------------------------------------------
  // Timing settings
  // ----------------------------------------------------------------------
  logic [15:0]       timing;
  logic [15:0]       next_timing;
  logic [TIME_W-1:0] adc_ms;
  logic [TIME_W-1:0] key_ms;
  logic [TIME_W-1:0] lkey_ms;
  logic [TIME_W-1:0] sww_ms;
  logic [3:0]        t_valid;

  fmd_time_decode u_dec (
    .i_adc_code  (timing[TF_ADC+:4]),
    .i_key_code  (timing[TF_KEY+:4]),
    .i_lkey_code (timing[TF_LKEY+:4]),
    .i_sww_code  (timing[TF_SWW+:4]),
    .o_adc_ms    (adc_ms),
    .o_key_ms    (key_ms),
    .o_lkey_ms   (lkey_ms),
    .o_sww_ms    (sww_ms),
    .o_valid     (t_valid)
  );

  // Each nibble is taken only if its code is defined; a bad code keeps
  // the old setting so the timers never run from an undefined value.
  always_comb begin
    logic [3:0] c;
    c = 4'h0;
    next_timing = timing;
    if (i_wr && i_addr == ADDR_TIMING) begin
      c = i_wdata[TF_ADC+:4];
      if (int'(c) <= ADC_MAX_CODE) next_timing[TF_ADC+:4] = c;
      c = i_wdata[TF_KEY+:4];
      if (int'(c) <= KEY_MAX_CODE) next_timing[TF_KEY+:4] = c;
      c = i_wdata[TF_LKEY+:4];
      if (int'(c) <= LKEY_MAX_CODE) next_timing[TF_LKEY+:4] = c;
      c = i_wdata[TF_SWW+:4];
      if (int'(c) <= SWW_MAX_CODE) next_timing[TF_SWW+:4] = c;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) timing <= TIMING_RST;
    else timing <= next_timing;
  end

  // ----------------------------------------------------------------------
  // Factory mode state machine
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FMD_S_STD, FMD_S_UART, FMD_S_USB, FMD_S_AUDIO
  } fmd_state_t;

  fmd_state_t state;
  fmd_state_t next_state;
  fmd_id_t    last_id;
  fmd_id_t    next_last_id;
  logic       jig_low_entry;
  logic       next_jig_low_entry;
  logic       boot;
  logic       next_boot;
  logic       fet;
  logic       next_fet;
  logic [2:0] ev;

  function automatic logic is_uart(input fmd_id_t id);
    return id == FMD_ID_619K || id == FMD_ID_523K;
  endfunction
  function automatic logic is_usb(input fmd_id_t id);
    return id == FMD_ID_301K || id == FMD_ID_255K;
  endfunction
  function automatic logic is_aud(input fmd_id_t id);
    return id == FMD_ID_1000K || id == FMD_ID_1002K;
  endfunction

  // A jig is recognised at once, with no wait timer and no read
  // acknowledge, because the processor may still be asleep.
  always_comb begin
    next_state         = state;
    next_last_id       = last_id;
    next_jig_low_entry = jig_low_entry;
    next_boot          = boot;
    next_fet           = fet;
    ev                 = 3'h0;
    case (state)
      FMD_S_STD: begin
        if (i_io_supply && (is_uart(i_id_class) || is_usb(i_id_class))) begin
          next_state   = is_uart(i_id_class) ? FMD_S_UART
                                             : FMD_S_USB;
          next_last_id = i_id_class;
          next_jig_low_entry = 1'b1; // jig output low in all factory modes
          ev[INT_ENTER] = 1'b1;
        end
      end
      default: begin
        if (i_id_class == FMD_ID_NONE || !i_io_supply) begin
          next_state = FMD_S_STD;
          next_last_id = FMD_ID_NONE;
          next_jig_low_entry = 1'b0;
          ev[INT_EXIT] = 1'b1;
        end else if (i_id_class != last_id) begin
          if (is_uart(i_id_class)) begin
            next_state = FMD_S_UART;
            next_last_id = i_id_class;
            ev[INT_CHANGE] = 1'b1;
          end else if (is_usb(i_id_class)) begin
            next_state = FMD_S_USB;
            next_last_id = i_id_class;
            ev[INT_CHANGE] = 1'b1;
          end else if (is_aud(i_id_class) && jig_low_entry) begin
            next_state = FMD_S_AUDIO;
            next_last_id = i_id_class;
            ev[INT_CHANGE] = 1'b1;
          end
          // Any other class leaves the paths as they are.
        end
      end
    endcase
    if (next_state != FMD_S_STD && next_last_id != last_id) begin
      next_boot = (next_last_id == FMD_ID_619K
                   || next_last_id == FMD_ID_301K);
      if (next_state == FMD_S_UART) next_fet = i_bus_supply_input;
      else if (next_state == FMD_S_USB) next_fet = 1'b1;
      else next_fet = 1'b0;
    end else if (next_state == FMD_S_STD) begin
      next_boot = 1'b0;
      next_fet  = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state         <= FMD_S_STD;
      last_id       <= FMD_ID_NONE;
      jig_low_entry <= 1'b0;
      boot          <= 1'b0;
      fet           <= 1'b0;
    end else begin
      state         <= next_state;
      last_id       <= next_last_id;
      jig_low_entry <= next_jig_low_entry;
      boot          <= next_boot;
      fet           <= next_fet;
    end
  end

  // ----------------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------------
  fmd_route_t next_route;
  always_comb begin
    case (next_state)
      FMD_S_UART:  next_route = FMD_RT_UART;
      FMD_S_USB:   next_route = FMD_RT_USB;
      FMD_S_AUDIO: next_route = FMD_RT_AUDIO;
      default:     next_route = FMD_RT_OPEN;
    endcase
  end

  // The jig output is held low in every mode, standard mode and reset
  // included; a present jig is signalled by a low level on that pin.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_route                 <= FMD_RT_OPEN;
      o_factory               <= 1'b0;
      o_jig_present           <= 1'b0;
      o_boot_request          <= 1'b0;
      o_charger_fet           <= 1'b0;
      o_charger_detect_out_oe <= 1'b0;
      o_microphone_line_en    <= 1'b0;
      o_key_sense_en          <= 1'b1;
    end else begin
      o_route                 <= next_route;
      o_factory               <= next_state != FMD_S_STD;
      o_jig_present           <= 1'b0;
      o_boot_request          <= next_boot;
      o_charger_fet           <= next_fet;
      o_charger_detect_out_oe <= 1'b0;
      o_microphone_line_en    <= 1'b0;
      o_key_sense_en          <= next_state == FMD_S_STD;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts and register reads
  // ----------------------------------------------------------------------
  logic [NUM_INT-1:0] int_stat;
  logic [NUM_INT-1:0] next_int_stat;
  logic [NUM_INT-1:0] mask;
  logic [NUM_INT-1:0] next_mask;
  logic [15:0]        next_rdata;

  // An event in the cycle of the clearing read is kept: set wins.
  always_comb begin
    next_int_stat = int_stat;
    if (i_rd && i_addr == ADDR_INT) next_int_stat = '0;
    next_int_stat = next_int_stat | ev;
    next_mask = mask;
    if (i_wr && i_addr == ADDR_MASK) next_mask = i_wdata[NUM_INT-1:0];
    next_rdata = 16'h0000;
    if (i_rd) begin
      if (i_addr == ADDR_TIMING) next_rdata = timing;
      else if (i_addr == ADDR_STATUS)
        next_rdata = {8'h00, t_valid, fet, boot, state[1:0]};
      else if (i_addr == ADDR_INT) next_rdata = {13'h0000, int_stat};
      else if (i_addr == ADDR_MASK) next_rdata = {13'h0000, mask};
      // The four decoded times sit at consecutive slots so that software
      // can see the figure each timer will really run from.
      else if (i_addr == ADDR_TIMES) next_rdata = {5'h00, adc_ms};
      else if (i_addr == ADDR_TIMES + 4'h1) next_rdata = {5'h00, key_ms};
      else if (i_addr == ADDR_TIMES + 4'h2) next_rdata = {5'h00, lkey_ms};
      else if (i_addr == ADDR_TIMES + 4'h3) next_rdata = {5'h00, sww_ms};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_stat <= '0;
      mask     <= MASK_RST;
      o_rdata  <= 16'h0000;
      o_irq    <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      mask     <= next_mask;
      o_rdata  <= next_rdata;
      o_irq    <= |(next_int_stat & next_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence jig_seen;
    i_io_supply && (is_uart(i_id_class) || is_usb(i_id_class));
  endsequence

  jig_entry_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == FMD_S_STD) and jig_seen |=> state != FMD_S_STD)
    else $error("jig not entered in one cycle");
  uart_route_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    state == FMD_S_UART |-> o_route == FMD_RT_UART)
    else $error("uart route wrong");
  usb_fet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state == FMD_S_USB |-> o_charger_fet && o_route == FMD_RT_USB)
    else $error("usb mode without fet or route");
  key_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state != FMD_S_STD |-> !o_key_sense_en)
    else $error("key sensing active in factory mode");
  exit_std_a: assert property (@(posedge i_clk) disable iff (i_rst)
    state != FMD_S_STD && i_id_class == FMD_ID_NONE |=> state == FMD_S_STD)
    else $error("no return to standard flow");
  boot_level_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    last_id == FMD_ID_619K |-> o_boot_request)
    else $error("boot request low for boot-on uart");
  audio_gate_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    $rose(state == FMD_S_AUDIO) |-> $past(jig_low_entry))
    else $error("audio entered without jig-low entry");
  other_hold_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    state != FMD_S_STD && i_io_supply && i_id_class == FMD_ID_OTHER
    |=> $stable(state))
    else $error("unsupported id changed mode");
  uart_fet_a: assert property (@(posedge i_clk)
    disable iff (i_rst)
    state == FMD_S_UART && i_io_supply && i_id_class == last_id
    |=> $stable(o_charger_fet))
    else $error("uart fet moved without a new id");

endmodule // fmd_factory_detect

// File: tb/fmd_jig_model.sv
// Model of the factory jig box and the supply sensing on the cable side.
module fmd_jig_model
  import fmd_pkg::*;
(
  input  wire logic         i_clk,
  output fmd_pkg::fmd_id_t  o_id_class,
  output logic              o_io_supply,
  output logic              o_bus_supply_input
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_id_class         = FMD_ID_NONE;
    o_io_supply        = 1'b0;
    o_bus_supply_input = 1'b0;
  end

  // Lines move just after an edge, so the detector never sees them mid-change.
  task automatic plug(input fmd_id_t id, input logic io, input logic vb);
    @(posedge i_clk);
    o_id_class         <= id;
    o_io_supply        <= io;
    o_bus_supply_input <= vb;
  endtask
endmodule // fmd_jig_model

// File: tb/testbench.sv
// Self-checking bench for the factory-mode detector and its timing decoder.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fmd_pkg::*;

  logic              i_clk, i_rst, io_sup, bus_sup, i_wr, i_rd;
  fmd_id_t           id_class, e_id;
  fmd_route_t        o_route, e_route;
  logic [3:0]        i_addr;
  logic [15:0]       i_wdata, o_rdata, got, w, w2;
  logic              o_fac, o_jig, o_boot, o_fet, o_oe, o_mic, o_key, o_irq;
  logic              e_fac, e_boot, e_fet;
  logic [2:0]        e_int, m;
  logic [4:0]        steps [14];
  integer            seed, miscompares, n_tests;

  fmd_jig_model fmd_jig_model_inst (.i_clk(i_clk), .o_id_class(id_class),
    .o_io_supply(io_sup), .o_bus_supply_input(bus_sup));
  fmd_factory_detect fmd_factory_detect_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_id_class(id_class), .i_io_supply(io_sup),
    .i_bus_supply_input(bus_sup), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_route(o_route),
    .o_factory(o_fac), .o_jig_present(o_jig), .o_boot_request(o_boot),
    .o_charger_fet(o_fet), .o_charger_detect_out_oe(o_oe),
    .o_microphone_line_en(o_mic), .o_key_sense_en(o_key), .o_irq(o_irq));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // --------------------------------------------------------------------
  // Reference functions and bus tasks
  // --------------------------------------------------------------------
  function automatic int lim(int f);
    return f == 0 ? 11 : f == 1 ? 9 : f == 2 ? 12 : 10;
  endfunction

  function automatic int ms_of(int f, int c);
    case (f)
      0: return c <= 3 ? 50 + 50 * c : 200 + 100 * (c - 3);
      1: return 100 + 100 * c;
      2: return 300 + 100 * c;
      default: return 10 + 20 * c;
    endcase
  endfunction

  function automatic logic [15:0] rnd_word();
    for (int f = 0; f < 4; f++) begin
      rnd_word[4*f +: 4] = 4'($unsigned($random(seed)) % (lim(f) + 1));
    end
  endfunction

  // Tracks the expected mode; an ignored ID keeps the old one as reference.
  function automatic void predict(fmd_id_t id, logic io, logic vb);
    logic was;
    fmd_id_t old;
    was = e_fac;
    old = e_id;
    if (id == FMD_ID_NONE || !io) begin
      e_fac = 1'b0;
      e_route = FMD_RT_OPEN;
      e_id = FMD_ID_NONE;
    end else if (id != e_id && id != FMD_ID_OTHER &&
                 (e_fac || id < FMD_ID_1000K)) begin
      e_fac = 1'b1;
      e_id = id;
      e_route = id < FMD_ID_301K ? FMD_RT_UART :
                id < FMD_ID_1000K ? FMD_RT_USB : FMD_RT_AUDIO;
      e_fet = id < FMD_ID_301K ? vb : id < FMD_ID_1000K;
    end
    e_boot = e_fac && (e_id == FMD_ID_619K || e_id == FMD_ID_301K);
    if (!e_fac) e_fet = 1'b0;
    if (e_fac != was) e_int[was ? INT_EXIT : INT_ENTER] = 1'b1;
    else if (e_fac && e_id != old) e_int[INT_CHANGE] = 1'b1;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask

  task automatic chk_mode;
    logic [8:0] e;
    e = {e_route, e_fac, 1'b0, e_boot, e_fet, 2'b00, !e_fac};
    chk("mode", 16'(e), 16'({o_route, o_fac, o_jig, o_boot,
        o_fet, o_oe, o_mic, o_key}));
  endtask

  // One attach step with a fresh random mask, then status and interrupts.
  task automatic step(input logic [4:0] s);
    m = 3'($random(seed));
    wr(ADDR_MASK, {13'h0000, m});
    fmd_jig_model_inst.plug(fmd_id_t'(s[4:2]), s[1], s[0]);
    predict(fmd_id_t'(s[4:2]), s[1], s[0]);
    @(posedge i_clk);
    #1 chk_mode;
    rd(ADDR_STATUS);
    chk("state", {8'h00, 4'hF, e_fet, e_boot, e_route}, got);
    chk("irq", 16'(|(e_int & m)), 16'(o_irq));
    rd(ADDR_INT);
    chk("int", 16'(e_int), got);
    e_int = 3'h0;
    repeat (2) @(posedge i_clk);
    #1 chk("irq_clear", 16'h0000, 16'(o_irq));
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    seed = 32'hE00908A4;
    miscompares = 0;
    n_tests = 0;
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 4'h0, 16'h0000};
    {e_fac, e_boot, e_fet, e_int} = 6'h00;
    e_route = FMD_RT_OPEN;
    e_id = FMD_ID_NONE;
    w = 16'h0000;
    steps = '{{FMD_ID_523K, 2'b10}, {FMD_ID_523K, 2'b11},
      {FMD_ID_619K, 2'b11}, {FMD_ID_301K, 2'b10}, {FMD_ID_1000K, 2'b11},
      {FMD_ID_OTHER, 2'b11}, {FMD_ID_1002K, 2'b10}, {FMD_ID_255K, 2'b11},
      {FMD_ID_NONE, 2'b11}, {FMD_ID_1000K, 2'b11}, {FMD_ID_301K, 2'b01},
      {FMD_ID_301K, 2'b11}, {FMD_ID_619K, 2'b01}, {FMD_ID_NONE, 2'b00}};
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk_mode;
    rd(ADDR_TIMING);
    chk("timing_reset", 16'h0000, got);
    rd(ADDR_MASK);
    chk("mask_reset", 16'h0000, got);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      w2 = {4'(c + 3), 4'(c + 2), 4'(c + 1), 4'(c)};
      wr(ADDR_TIMING, w2);
      for (int f = 0; f < 4; f++) begin
        if (int'(w2[4*f +: 4]) <= lim(f)) w[4*f +: 4] = w2[4*f +: 4];
      end
      rd(ADDR_TIMING);
      chk("code_held", w, got);
      for (int f = 0; f < 4; f++) begin
        int cf;
        cf = int'(w[4*f +: 4]);
        rd(ADDR_TIMES + 4'(f));
        chk("code_ms", 16'(ms_of(f, cf)), got);
      end
    end
    $display("test decode done");
    for (int f = 0; f < 4; f++) begin
      w = rnd_word();
      wr(ADDR_TIMING, w);
      rd(ADDR_TIMING);
      chk("timing", w, got);
      w2 = rnd_word();
      w2[4*f +: 4] = 4'hF;
      wr(ADDR_TIMING, w2);
      rd(ADDR_TIMING);
      w2[4*f +: 4] = w[4*f +: 4];
      chk("timing_bad", w2, got);
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk("unmapped", 16'h0000, got);
    rd(ADDR_TIMING);
    chk("timing_kept", w2, got);
    $display("test timing done");
    foreach (steps[k]) step(steps[k]);
    $display("test factory sequence done");
    for (int k = 0; k < 40; k++) begin
      step({3'($unsigned($random(seed)) % 7), ($random(seed) % 4 != 0),
            1'($random(seed))});
    end
    $display("test random attach done");
    fmd_jig_model_inst.plug(FMD_ID_301K, 1'b1, 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    {e_fac, e_boot, e_fet, e_int} = 6'h00;
    e_route = FMD_RT_OPEN;
    e_id = FMD_ID_NONE;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1 chk_mode;
    step({FMD_ID_301K, 2'b11});
    rd(ADDR_TIMING);
    chk("timing_rerst", 16'h0000, got);
    $display("test mid-run reset done");
    test_done;
  end

  // The whole run needs about 800 cycles; this leaves ample margin.
  initial begin
    repeat (8000) @(posedge i_clk);
    miscompares++;
    test_done;
  end
endmodule // testbench
